//--- inc/sos_defines.svh
`ifndef SOS_DEFINES_SVH
`define SOS_DEFINES_SVH
// ==========================================================
// Register map
`define SOS_PROGRESS_ADDR 20'hFFFA2
`define SOS_WAITSEL_ADDR  20'hFFFA3
`define SOS_PROGRESS_RST  8'h00
`define SOS_WAITSEL_RST   3'h7
`define SOS_WAITSEL_LSB   0
`define SOS_WAITSEL_W     3
// ==========================================================
// Resume delays in CPU clocks
`define SOS_WAKE_SVC      4'hA
`define SOS_WAKE_PLAIN    4'h5
`endif

//--- inc/sos_pkg.sv
package sos_pkg;
  // ==========================================================
  // Standby sequencer states
  typedef enum logic [4:0] {
    SOS_RUN    = 5'h01,
    SOS_HALT   = 5'h02,
    SOS_STOP   = 5'h04,
    SOS_SETTLE = 5'h08,
    SOS_WAKE   = 5'h10
  } sos_state_t;

  // Crystal cycles needed for a wait-select code
  function automatic logic [18:0] sos_thr_f(input logic [2:0] code);
    unique case (code)
      3'h0: sos_thr_f = 19'h00100;
      3'h1: sos_thr_f = 19'h00200;
      3'h2: sos_thr_f = 19'h00400;
      3'h3: sos_thr_f = 19'h00800;
      3'h4: sos_thr_f = 19'h02000;
      3'h5: sos_thr_f = 19'h08000;
      3'h6: sos_thr_f = 19'h20000;
      3'h7: sos_thr_f = 19'h40000;
    endcase
  endfunction : sos_thr_f
endpackage : sos_pkg

//--- inc/sos_cnt_if.sv
`timescale 1ns/10ps
interface sos_cnt_if;
  logic       clr;
  logic       tick;
  logic [2:0] sel;
  logic [7:0] status;
  logic       done;
  modport ctl (output clr, output tick, output sel, input status, input done);
  modport cnt (input clr, input tick, input sel, output status, output done);
endinterface : sos_cnt_if

//--- logic/sos_settle_counter.sv
`timescale 1ns/10ps
`include "sos_defines.svh"
module sos_settle_counter import sos_pkg::*; #(
  parameter int CNT_W = 19
) (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  sos_cnt_if.cnt    cif
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0]       thermo;
  logic             done_c;

  // ==========================================================
  // Count crystal cycles, hold at the selected wait
  assign done_c = (19'(cnt_q) >= sos_thr_f(cif.sel));

  always_comb begin
    cnt_d = cnt_q;
    if (cif.clr) begin
      cnt_d = '0;
    end else if (cif.tick && !done_c) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Thermometer status, one bit per threshold
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_thermo
      assign thermo[gi] = (19'(cnt_q) >= sos_thr_f(3'(gi)));
    end
  endgenerate

  assign cif.status = thermo;
  assign cif.done   = done_c;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i || !ce_i);

  AST_CLR_ZERO: assert property (cif.clr |=> cif.status == 8'h00)
    else $error("status not cleared");
  AST_THERMO: assert property (((cif.status + 8'h01) & cif.status) == 8'h00)
    else $error("status not thermometer");
  AST_CAP: assert property ($stable(cif.sel) && !cif.clr && cif.done |=> $stable(cnt_q))
    else $error("counter ran past selected wait");
  AST_NO_TICK: assert property (!cif.tick && !cif.clr |=> $stable(cnt_q))
    else $error("counted without crystal");
  CV_FULL: cover property (cif.status == 8'hFF);
endmodule : sos_settle_counter

//--- logic/sos_standby_ctrl.sv
`timescale 1ns/10ps
`include "sos_defines.svh"
// Operation
// - Halt gates CPU clock; running high-speed oscillators keep going.
// - Stop halts crystal and internal high-speed oscillators.
// - Registers, flags and memory keep their values in standby.
// - Port latches and output buffers stay unchanged in standby.
// - An interrupt request ends the stop state.
// - On crystal CPU clock, hold execution until selected wait elapses.
// - A configuration input decides low-speed oscillator in standby.
// - Progress register is read-only, readable by bit or byte.
// - Progress clears on reset, stop, and main oscillator halt write.
// - Progress bits set as thermometer at eight thresholds, stay set.
// - Counter stops at the selected wait time.
// - Wait select resets to 07H, 3-bit code, upper bits zero.
// - Wait select writable only by byte access.
// - Counting starts only once the crystal oscillates.
// - Unmasked interrupt ends halt; resume after 10 or 5 clocks.
// - Reset ends either standby state as a normal reset.
// - Pending interrupt at stop falls back, resumes after the wait.
module sos_standby_ctrl import sos_pkg::*; (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  input  wire logic        halt_req_i,
  input  wire logic        stop_req_i,
  input  wire logic        irq_pending_i,
  input  wire logic        irq_ack_en_i,
  input  wire logic        cpu_on_xtal_i,
  input  wire logic        lowspeed_keep_i,
  input  wire logic        xtal_tick_i,
  input  wire logic        main_osc_halt_wr_i,
  input  wire logic [19:0] bus_addr_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic        bus_bit_i,
  input  wire logic [7:0]  bus_wdata_i,
  output logic      [7:0]  bus_rdata_o,
  output logic             cpu_clk_en_o,
  output logic             xtal_osc_run_o,
  output logic             int_osc_run_o,
  output logic             lowspeed_run_o,
  output logic             standby_hold_o,
  output logic             cpu_resume_o
);
  sos_cnt_if cif ();

  sos_state_t state_q, state_d;
  logic [3:0] wcnt_q, wcnt_d;
  logic [2:0] sel_q, sel_d;
  logic [7:0] rdata_d;
  logic       clk_en_d, xosc_d, iosc_d, losc_d, hold_d, resume_d;
  logic       stop_go;

  // ==========================================================
  // Register access
  always_comb begin
    sel_d   = sel_q;
    rdata_d = 8'h00;
    // Bit writes are dropped: the select is reached only as a whole byte
    if (bus_wr_i && !bus_bit_i && bus_addr_i == `SOS_WAITSEL_ADDR) begin
      sel_d = bus_wdata_i[`SOS_WAITSEL_LSB +: `SOS_WAITSEL_W];
    end
    if (bus_rd_i && bus_addr_i == `SOS_PROGRESS_ADDR) begin
      rdata_d = cif.status;
    end else if (bus_rd_i && bus_addr_i == `SOS_WAITSEL_ADDR) begin
      rdata_d = {5'h00, sel_q};
    end
  end

  // ==========================================================
  // Standby sequencer
  // Halt wins a tie with stop; a stop still clears the count when it falls back
  assign stop_go  = (state_q == SOS_RUN) && stop_req_i && !halt_req_i;
  assign cif.clr  = stop_go || main_osc_halt_wr_i;
  assign cif.tick = xtal_tick_i && (state_q != SOS_STOP);
  assign cif.sel  = sel_q;

  always_comb begin
    state_d  = state_q;
    wcnt_d   = wcnt_q;
    resume_d = 1'b0;
    unique case (state_q)
      SOS_RUN: begin
        if (halt_req_i) begin
          state_d = SOS_HALT;
        end else if (stop_req_i) begin
          state_d = irq_pending_i ? SOS_SETTLE : SOS_STOP;
        end
      end
      SOS_HALT: begin
        if (irq_pending_i) begin
          state_d = SOS_WAKE;
          wcnt_d  = irq_ack_en_i ? `SOS_WAKE_SVC - 4'h2 : `SOS_WAKE_PLAIN - 4'h2;
        end
      end
      SOS_STOP: begin
        if (irq_pending_i) begin
          state_d = SOS_SETTLE;
        end
      end
      SOS_SETTLE: begin
        // Internal clock CPU need not wait; software polls progress instead
        if (!cpu_on_xtal_i || cif.done) begin
          state_d = SOS_WAKE;
          wcnt_d  = irq_ack_en_i ? `SOS_WAKE_SVC - 4'h2 : `SOS_WAKE_PLAIN - 4'h2;
        end
      end
      SOS_WAKE: begin
        if (wcnt_q == 4'h0) begin
          state_d  = SOS_RUN;
          resume_d = 1'b1;
        end else begin
          wcnt_d = wcnt_q - 4'h1;
        end
      end
    endcase
    clk_en_d = (state_d == SOS_RUN);
    xosc_d   = (state_d != SOS_STOP);
    iosc_d   = (state_d != SOS_STOP);
    losc_d   = (state_d == SOS_RUN) || (state_d == SOS_WAKE) || lowspeed_keep_i;
    hold_d   = (state_d != SOS_RUN);
  end

  // Reset returns to run from any standby state
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q        <= SOS_RUN;
      wcnt_q         <= 4'h0;
      sel_q          <= `SOS_WAITSEL_RST;
      bus_rdata_o    <= 8'h00;
      cpu_clk_en_o   <= 1'b1;
      xtal_osc_run_o <= 1'b1;
      int_osc_run_o  <= 1'b1;
      lowspeed_run_o <= 1'b1;
      standby_hold_o <= 1'b0;
      cpu_resume_o   <= 1'b0;
    end else if (ce_i) begin
      state_q        <= state_d;
      wcnt_q         <= wcnt_d;
      sel_q          <= sel_d;
      bus_rdata_o    <= rdata_d;
      cpu_clk_en_o   <= clk_en_d;
      xtal_osc_run_o <= xosc_d;
      int_osc_run_o  <= iosc_d;
      lowspeed_run_o <= losc_d;
      standby_hold_o <= hold_d;
      cpu_resume_o   <= resume_d;
    end
  end

  sos_settle_counter #(
    .CNT_W (19)
  ) u_cnt (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .cif       (cif)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i || !ce_i);

  AST_HALT_GATE: assert property (state_q == SOS_HALT |-> !cpu_clk_en_o && xtal_osc_run_o)
    else $error("halt clock gating wrong");
  AST_STOP_OSC: assert property (state_q == SOS_STOP |-> !xtal_osc_run_o && !int_osc_run_o)
    else $error("oscillators not stopped");
  AST_HOLD: assert property (state_q != SOS_RUN |-> standby_hold_o)
    else $error("hold not asserted in standby");
  AST_LS: assert property (state_q inside {SOS_HALT, SOS_STOP} && !$past(lowspeed_keep_i)
                           |-> !lowspeed_run_o)
    else $error("low-speed oscillator not stopped");
  AST_BIT_WR: assert property (bus_wr_i && bus_bit_i |=> $stable(sel_q))
    else $error("bit write changed wait select");
  AST_RO: assert property (bus_rd_i && bus_addr_i == `SOS_PROGRESS_ADDR |=> bus_rdata_o == $past(cif.status))
    else $error("progress read wrong");
  AST_WAKE_SVC: assert property (state_q == SOS_HALT && irq_pending_i && irq_ack_en_i
                                 |-> ##1 !cpu_clk_en_o[*8] ##1 !cpu_clk_en_o ##1 cpu_clk_en_o)
    else $error("serviced resume not after 10 clocks");
  AST_WAKE_PLAIN: assert property (state_q == SOS_HALT && irq_pending_i && !irq_ack_en_i
                                   |-> ##1 !cpu_clk_en_o[*4] ##1 cpu_clk_en_o)
    else $error("plain resume not after 5 clocks");
  AST_SETTLE: assert property (state_q == SOS_SETTLE && cpu_on_xtal_i && !cif.done |=> !cpu_clk_en_o)
    else $error("CPU ran before crystal settled");
  AST_STOP_CLR: assert property (stop_go |=> cif.status == 8'h00)
    else $error("stop did not clear progress");

  // ==========================================================
  // Entry, exit and register checks
  AST_STOP_ENTRY: assert property (stop_go && !irq_pending_i |=> state_q == SOS_STOP)
    else $error("stop not entered");
  AST_STOP_EXIT: assert property (state_q == SOS_STOP && irq_pending_i |=> state_q == SOS_SETTLE)
    else $error("interrupt did not end stop");
  AST_FALLBACK: assert property (stop_go && irq_pending_i |=> state_q == SOS_SETTLE && cif.status == 8'h00)
    else $error("pending interrupt did not fall back");
  AST_RESUME: assert property (cpu_resume_o && $past(ce_i) |-> cpu_clk_en_o && !$past(cpu_clk_en_o))
    else $error("resume pulse without clock start");
  AST_LS_RUN: assert property (state_q inside {SOS_RUN, SOS_WAKE} |-> lowspeed_run_o)
    else $error("low-speed oscillator off while running");
  AST_SEL_READ: assert property (bus_rd_i && bus_addr_i == `SOS_WAITSEL_ADDR |=> bus_rdata_o[7:3] == 5'h00)
    else $error("upper select bits not zero");
  AST_SEL_KEEP: assert property (!bus_wr_i |=> $stable(sel_q))
    else $error("wait select changed without a write");
  AST_PROG_WR: assert property (bus_wr_i && bus_addr_i == `SOS_PROGRESS_ADDR && !cif.clr && !cif.tick
                                |=> $stable(cif.status))
    else $error("write reached progress register");

  CV_HALT: cover property (state_q == SOS_HALT ##[1:20] cpu_resume_o);
  CV_STOP: cover property (state_q == SOS_STOP ##1 state_q == SOS_SETTLE);
  CV_FALLBACK: cover property (state_q == SOS_RUN && stop_req_i && irq_pending_i);

  CV_SETTLE_WAIT: cover property (state_q == SOS_SETTLE && cpu_on_xtal_i ##1 state_q == SOS_WAKE);
endmodule : sos_standby_ctrl

//--- test/sos_cpu_model.sv
`timescale 1ns/10ps
// ==========================================================
// CPU side: issues standby instructions and interrupt requests
module sos_cpu_model (
  input  wire logic mclk_i,
  output logic      halt_req_o,
  output logic      stop_req_o,
  output logic      irq_o,
  output logic      ie_o,
  output logic      on_xtal_o
);
  initial begin
    halt_req_o = 1'b0;
    stop_req_o = 1'b0;
    irq_o      = 1'b0;
    ie_o       = 1'b0;
    on_xtal_o  = 1'b0;
  end
  task automatic halt(input logic ie);
    @(posedge mclk_i);
    ie_o       <= ie;
    halt_req_o <= 1'b1;
    @(posedge mclk_i);
    halt_req_o <= 1'b0;
  endtask : halt
  // Peripherals and converter already idle; xtal picks the crystal or the internal CPU clock
  // Wait select is programmed by the caller before this call
  task automatic stop(input logic xtal, input logic ie);
    @(posedge mclk_i);
    ie_o       <= ie;
    on_xtal_o  <= xtal;
    stop_req_o <= 1'b1;
    @(posedge mclk_i);
    stop_req_o <= 1'b0;
  endtask : stop
  task automatic irq(input logic v);
    @(posedge mclk_i);
    irq_o <= v;
  endtask : irq
endmodule : sos_cpu_model

//--- test/tb_top.sv
`timescale 1ns/10ps
`include "sos_defines.svh"
module tb_top;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i, ce, tick, mohw, ls_keep;
  logic        wr, rd, bit_acc;
  logic [19:0] addr;
  logic [7:0]  wdata, rdata, v;
  logic        halt_r, stop_r, irq, ie, on_xtal, cpu_en, x_run, i_run, ls_run, hold, resume;
  int          miscompares = 0, samples_checked = 0, n;
  wire  [7:0]  st = {2'b00, cpu_en, x_run, i_run, ls_run, hold, resume};
  always #2.5 mclk_i = ~mclk_i;
  sos_cpu_model cpu (.mclk_i(mclk_i), .halt_req_o(halt_r), .stop_req_o(stop_r), .irq_o(irq), .ie_o(ie),
    .on_xtal_o(on_xtal));
  sos_standby_ctrl dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .halt_req_i(halt_r),
    .stop_req_i(stop_r), .irq_pending_i(irq), .irq_ack_en_i(ie), .cpu_on_xtal_i(on_xtal),
    .lowspeed_keep_i(ls_keep), .xtal_tick_i(tick), .main_osc_halt_wr_i(mohw), .bus_addr_i(addr),
    .bus_wr_i(wr), .bus_rd_i(rd), .bus_bit_i(bit_acc), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
    .cpu_clk_en_o(cpu_en), .xtal_osc_run_o(x_run), .int_osc_run_o(i_run), .lowspeed_run_o(ls_run),
    .standby_hold_o(hold), .cpu_resume_o(resume));
  // ==========================================================
  // Access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task automatic bus_wr(input logic [19:0] a, input logic [7:0] d, input logic b);
    @(posedge mclk_i);
    addr    <= a;
    wdata   <= d;
    bit_acc <= b;
    wr      <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [19:0] a);
    @(posedge mclk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : bus_rd
  // Ticks stand for crystal cycles once it really oscillates
  task automatic ticks(input int k);
    repeat (k) @(posedge mclk_i) tick <= 1'b1;
    @(posedge mclk_i) tick <= 1'b0;
  endtask : ticks
  task automatic osc_halt_wr();
    @(posedge mclk_i) mohw <= 1'b1;
    @(posedge mclk_i) mohw <= 1'b0;
  endtask : osc_halt_wr
  // Bounded wait for the CPU clock; n counts edges from the call of this task
  task automatic wait_run(input int lim);
    #1;
    n = 0;
    while (cpu_en !== 1'b1) begin
      @(posedge mclk_i);
      #1 n++;
      if (n > lim) begin
        miscompares++;
        $display("unexpected at %0t: cpu clock never resumed", $time);
        summarize();
      end
    end
  endtask : wait_run
  // ==========================================================
  // Scenarios
  initial begin
    sys_rst_i <= 1'b1;
    ce        <= 1'b1;
    tick      <= 1'b0;
    mohw      <= 1'b0;
    ls_keep   <= 1'b0;
    wr        <= 1'b0;
    rd        <= 1'b0;
    bit_acc   <= 1'b0;
    addr      <= 20'h00000;
    wdata     <= 8'h00;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    #1 chk(st, 8'h3C);
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h00);
    bus_rd(`SOS_WAITSEL_ADDR); chk(v, 8'h07);
    bus_rd(20'hFFFA4); chk(v, 8'h00);
    bus_wr(`SOS_WAITSEL_ADDR, 8'h02, 1'b1);
    bus_rd(`SOS_WAITSEL_ADDR); chk(v, 8'h07);
    bus_wr(`SOS_WAITSEL_ADDR, 8'hF8, 1'b0);       // Shortest wait, legal at a slow crystal
    bus_rd(`SOS_WAITSEL_ADDR); chk(v, 8'h00);
    bus_wr(`SOS_PROGRESS_ADDR, 8'hFF, 1'b0);
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h00);
    osc_halt_wr();
    ticks(255);
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h00);
    ticks(1);
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h01);
    ticks(300);
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h01);
    bus_wr(`SOS_WAITSEL_ADDR, 8'h01, 1'b0);       // Count finished before rewrite
    ticks(256);
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h03);
    osc_halt_wr();
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h00);
    @(posedge mclk_i) ce <= 1'b0;
    ticks(256);
    @(posedge mclk_i) ce <= 1'b1;
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h00);
    bus_wr(`SOS_WAITSEL_ADDR, 8'h00, 1'b0);
    for (int i = 0; i < 2; i++) begin
      ls_keep <= i[0];
      cpu.halt(i[0]);
      @(posedge mclk_i);
      #1 chk(st, 8'h1A | {5'h00, i[0], 2'b00});
      bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h00);
      cpu.irq(1'b1);
      wait_run(30);
      chk(8'(n), i[0] ? 8'h0A : 8'h05);
      chk(st, 8'h3D);
      cpu.irq(1'b0);
    end
    ls_keep <= 1'b0;
    ticks(300);
    cpu.stop(1'b1, 1'b0);
    @(posedge mclk_i);
    #1 chk(st, 8'h02);
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h00);
    cpu.irq(1'b1);
    repeat (3) @(posedge mclk_i);
    #1 chk(st, 8'h1A);
    ticks(255);
    #1 chk(st, 8'h1A);
    ticks(1);
    wait_run(30);
    chk(8'(n), 8'h05);
    cpu.irq(1'b0);
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h01);
    ticks(300);
    cpu.irq(1'b1);
    cpu.stop(1'b0, 1'b1);
    wait_run(15);
    chk(8'(n), 8'h0A);
    cpu.irq(1'b0);
    bus_rd(`SOS_PROGRESS_ADDR); chk(v, 8'h00);    // Polled before any clock switch
    cpu.halt(1'b0);
    #1 chk(st, 8'h1A);
    @(posedge mclk_i) sys_rst_i <= 1'b1;
    @(posedge mclk_i) sys_rst_i <= 1'b0;
    #1 chk(st, 8'h3C);
    bus_rd(`SOS_WAITSEL_ADDR); chk(v, 8'h07);
    summarize();
  end
endmodule : tb_top
